// >>> core/lac_pkg.sv
// package: register map, fields, timing and state types of the latch acknowledge controller
// Functional notes
// - protection alarm clears self-clearing LED latches
// - self-clear on alarm is per-LED setting
// - remote commands need remote permit active
// - separate clears: system LED, LEDs, relays, SCADA, trips
// - combined command clears LEDs, relays, SCADA, trips
// - clear key ignored in parameter setting mode
// - menu still reachable in parameter setting mode
// - short press opens menu, wrench confirms selection
// - one-second hold clears long-press scope immediately
// - scope nothing ignores long presses
// - LEDs-without-password scope clears LEDs, no password
// - LEDs scope clears LEDs after password
// - LEDs-and-relays scope clears both after password
// - everything scope clears LEDs, relays, SCADA, trips (not system LED) after password
// - LED clear runs red then green test (alarm self-clear of LEDs starts no test)
// - other paths may require access password
// - empty level-one password skips prompt
// - clear only when setting source inactive
// - permit off: only panel key acknowledges
// - relay released only after off-delay elapses
package lac_pkg;
    localparam int          LAC_NLED        = 16;
    localparam int          LAC_NREL        = 8;
    localparam int          LAC_NSCD        = 8;
    localparam int          LAC_NSG         = 4;
    localparam int          LAC_CLK_HZ      = 40000000;
    localparam int          LAC_LONG_MS     = 1000;
    localparam int          LAC_TEST_MS     = 1000;
    localparam int          LAC_LONG_CYC    = LAC_CLK_HZ / 1000 * LAC_LONG_MS;
    localparam int          LAC_TEST_CYC    = LAC_CLK_HZ / 1000 * LAC_TEST_MS;
    localparam int          LAC_OFFDLY_CYC  = 4000;
    localparam logic [7:0]  LAC_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  LAC_CMD_ADDR    = 8'h04;
    localparam logic [7:0]  LAC_ALMSEL_ADDR = 8'h08;
    localparam logic [7:0]  LAC_MENU_ADDR   = 8'h0C;
    localparam logic [7:0]  LAC_STAT_ADDR   = 8'h10;
    localparam logic [7:0]  LAC_LED_ADDR    = 8'h14;
    localparam logic [7:0]  LAC_OUT_ADDR    = 8'h18;
    localparam int          LAC_CTRL_PERMIT = 0;
    localparam int          LAC_CTRL_PWOK   = 1;
    localparam int          LAC_CTRL_PWEMP  = 2;
    localparam int          LAC_CTRL_SCOPE  = 4;
    localparam int          LAC_CMD_SYS     = 0;
    localparam int          LAC_CMD_LED     = 1;
    localparam int          LAC_CMD_REL     = 2;
    localparam int          LAC_CMD_SCD     = 3;
    localparam int          LAC_CMD_ALL     = 4;
    localparam int          LAC_CMD_SG      = 8;
    localparam logic [31:0] LAC_CTRL_RST    = 32'h0000_0010;

    typedef enum logic [2:0] {
        LAC_SC_NOTHING, LAC_SC_LED_NOPW, LAC_SC_LED, LAC_SC_LED_REL, LAC_SC_ALL
    } lac_scope_type;

    typedef enum {LAC_T_IDLE, LAC_T_RED, LAC_T_GREEN} lac_test_type;

    typedef struct packed {
        logic                 sys;
        logic                 led;
        logic                 rel;
        logic                 scd;
        logic [LAC_NSG-1:0]   sg;
    } lac_clear_type;

    typedef struct packed {
        logic                 alarm;
        logic                 key;
        logic                 param_mode;
        logic                 wrench;
        logic                 sys_src;
        logic [LAC_NLED-1:0]  led_src;
        logic [LAC_NREL-1:0]  rel_src;
        logic [LAC_NSCD-1:0]  scd_src;
        logic [LAC_NSG-1:0]   trip_src;
    } lac_in_type;
endpackage

// >>> core/lac_top.sv
// latch acknowledge controller with its AHB-Lite register slave
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module lac_top
    import lac_pkg::*;
#(
    parameter int LONG_CYC   = LAC_LONG_CYC,
    parameter int TEST_CYC   = LAC_TEST_CYC,
    parameter int OFFDLY_CYC = LAC_OFFDLY_CYC
)(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire lac_in_type          pins,
    output logic                     system_indicator,
    output logic [LAC_NLED-1:0]      led_latched,
    output logic [LAC_NREL-1:0]      relay_out,
    output logic [LAC_NSCD-1:0]      scada_latched,
    output logic [LAC_NSG-1:0]       trip_latched,
    output logic                     led_test_red,
    output logic                     led_test_green,
    output logic                     menu_open,
    output logic                     pw_request
);
    localparam int CW = 32;

    typedef struct packed {
        lac_in_type           s1;
        lac_in_type           s2;
        logic                 key_q;
        logic                 alarm_q;
        logic [CW-1:0]        key_cnt;
        logic                 long_done;
        logic [31:0]          ctrl;
        logic [LAC_NLED-1:0]  almsel;
        lac_clear_type        menu_sel;
        logic                 menu;
        lac_clear_type        pend;
        logic                 pw_wait;
        lac_test_type         test;
        logic [CW-1:0]        test_cnt;
        logic                 sys;
        logic [LAC_NLED-1:0]  led;
        logic [LAC_NREL-1:0]  rel;
        logic [LAC_NREL-1:0]  rel_out;
        logic [LAC_NREL-1:0][CW-1:0] offd;
        logic [LAC_NSCD-1:0]  scd;
        logic [LAC_NSG-1:0]   trip;
        logic                 a_act;
        logic                 a_wr;
        logic [7:0]           a_addr;
        logic [31:0]          rdata;
    } lac_state_type;

    lac_state_type st, next_st;

    function automatic lac_clear_type lac_decode(input logic [31:0] v);
        lac_clear_type c;
        c.sys = v[LAC_CMD_SYS];
        c.led = v[LAC_CMD_LED] | v[LAC_CMD_ALL];
        c.rel = v[LAC_CMD_REL] | v[LAC_CMD_ALL];
        c.scd = v[LAC_CMD_SCD] | v[LAC_CMD_ALL];
        c.sg  = v[LAC_CMD_SG +: LAC_NSG] | {LAC_NSG{v[LAC_CMD_ALL]}};
        return c;
    endfunction

    lac_scope_type scope;
    logic          key_fall, long_hit, pw_free, bus_wr, alarm_clr;
    lac_clear_type req, remote;

    always_comb
    begin
        next_st = st;
        req = '0;
        remote = '0;
        scope = lac_scope_type'(st.ctrl[LAC_CTRL_SCOPE +: 3]);
        pw_free = st.ctrl[LAC_CTRL_PWEMP] | st.ctrl[LAC_CTRL_PWOK];
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.key_q = st.s2.key;
        next_st.alarm_q = st.s2.alarm;
        // bus data phase
        bus_wr = st.a_act & st.a_wr;
        next_st.a_act = hsel & htrans[1] & hready;
        next_st.a_wr = hwrite;
        next_st.a_addr = haddr[7:0];
        if (bus_wr && st.a_addr == LAC_CTRL_ADDR)
        begin
            next_st.ctrl = hwdata;
        end
        else if (bus_wr && st.a_addr == LAC_ALMSEL_ADDR)
        begin
            next_st.almsel = hwdata[LAC_NLED-1:0];
        end
        else if (bus_wr && st.a_addr == LAC_MENU_ADDR)
        begin
            next_st.menu_sel = lac_decode(hwdata);
        end
        if (bus_wr && st.a_addr == LAC_CMD_ADDR && st.ctrl[LAC_CTRL_PERMIT])
        begin
            remote = lac_decode(hwdata);
        end
        // key timing; disabled in parameter mode
        key_fall = st.key_q & ~st.s2.key;
        long_hit = 1'b0;
        if (st.s2.key && !st.s2.param_mode)
        begin
            if (!st.long_done)
            begin
                next_st.key_cnt = st.key_cnt + 1'b1;
            end
            if (st.key_cnt == CW'(LONG_CYC - 1) && !st.long_done)
            begin
                long_hit = 1'b1;
                next_st.long_done = 1'b1;
            end
        end
        else
        begin
            next_st.key_cnt = '0;
            next_st.long_done = 1'b0;
        end
        if (key_fall && !st.long_done)
        begin
            next_st.menu = 1'b1;   // menu reachable in any mode
        end
        if (long_hit && scope != LAC_SC_NOTHING)
        begin
            next_st.pend.led = 1'b1;
            next_st.pend.rel = (scope == LAC_SC_LED_REL) | (scope == LAC_SC_ALL);
            next_st.pend.scd = scope == LAC_SC_ALL;
            next_st.pend.sg  = {LAC_NSG{scope == LAC_SC_ALL}};
            next_st.pend.sys = 1'b0;
            next_st.pw_wait = scope != LAC_SC_LED_NOPW && !(scope == LAC_SC_LED && pw_free);
            next_st.pw_wait = next_st.pw_wait && !((next_st.pend.rel) && pw_free);
        end
        if (st.menu && st.s2.wrench)
        begin
            next_st.menu = 1'b0;
            next_st.pend = st.menu_sel;
            next_st.pw_wait = ~pw_free;
        end
        if (st.pw_wait && st.ctrl[LAC_CTRL_PWOK])
        begin
            next_st.pw_wait = 1'b0;
        end
        if (!st.pw_wait && st.pend != '0)
        begin
            req = st.pend;
            next_st.pend = '0;
        end
        req = req | remote;
        // alarm clearing is not a panel key path, so it needs the permit too
        alarm_clr = st.s2.alarm & ~st.alarm_q & st.ctrl[LAC_CTRL_PERMIT];
        // set latches from sources, clear only once source gone
        next_st.sys = st.sys | st.s2.sys_src;
        if (req.sys && !st.s2.sys_src)
        begin
            next_st.sys = 1'b0;
        end
        for (int i = 0; i < LAC_NLED; i++)
        begin
            next_st.led[i] = st.led[i] | st.s2.led_src[i];
            if ((req.led || (alarm_clr && st.almsel[i])) && !st.s2.led_src[i])
            begin
                next_st.led[i] = 1'b0;
            end
        end
        for (int i = 0; i < LAC_NREL; i++)
        begin
            next_st.rel[i] = st.rel[i] | st.s2.rel_src[i];
            if (req.rel && !st.s2.rel_src[i])
            begin
                next_st.rel[i] = 1'b0;
            end
            if (st.rel[i])
            begin
                next_st.offd[i] = CW'(OFFDLY_CYC);
                next_st.rel_out[i] = 1'b1;
            end
            else if (st.offd[i] != '0)
            begin
                next_st.offd[i] = st.offd[i] - 1'b1;
            end
            else
            begin
                next_st.rel_out[i] = 1'b0;
            end
        end
        for (int i = 0; i < LAC_NSCD; i++)
        begin
            next_st.scd[i] = (st.scd[i] | st.s2.scd_src[i]) & ~(req.scd & ~st.s2.scd_src[i]);
        end
        for (int i = 0; i < LAC_NSG; i++)
        begin
            next_st.trip[i] = (st.trip[i] | st.s2.trip_src[i])
                              & ~(req.sg[i] & ~st.s2.trip_src[i]);
        end
        // test runs on every req.led clear, not on alarm self-clears, restarting if repeated
        case (st.test)
            LAC_T_IDLE:
            begin
                next_st.test_cnt = '0;
            end
            LAC_T_RED:
            begin
                next_st.test_cnt = st.test_cnt + 1'b1;
                if (st.test_cnt == CW'(TEST_CYC - 1))
                begin
                    next_st.test = LAC_T_GREEN;
                    next_st.test_cnt = '0;
                end
            end
            default:
            begin
                next_st.test_cnt = st.test_cnt + 1'b1;
                if (st.test_cnt == CW'(TEST_CYC - 1))
                begin
                    next_st.test = LAC_T_IDLE;
                end
            end
        endcase
        if (req.led)
        begin
            next_st.test = LAC_T_RED;
            next_st.test_cnt = '0;
        end
        // read mux
        next_st.rdata = '0;
        if (haddr[7:0] == LAC_CTRL_ADDR)
        begin
            next_st.rdata = st.ctrl;
        end
        else if (haddr[7:0] == LAC_ALMSEL_ADDR)
        begin
            next_st.rdata = 32'(st.almsel);
        end
        else if (haddr[7:0] == LAC_MENU_ADDR)
        begin
            next_st.rdata = 32'(st.menu_sel);
        end
        else if (haddr[7:0] == LAC_STAT_ADDR)
        begin
            next_st.rdata = {24'h0, st.pend != '0, st.pw_wait, st.menu, st.sys,
                             st.test == LAC_T_GREEN, st.test == LAC_T_RED, 2'h0};
        end
        else if (haddr[7:0] == LAC_LED_ADDR)
        begin
            next_st.rdata = 32'(st.led);
        end
        else if (haddr[7:0] == LAC_OUT_ADDR)
        begin
            next_st.rdata = {4'h0, st.trip, st.scd, st.rel_out, st.rel};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
            st.ctrl <= LAC_CTRL_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hrdata         = st.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign system_indicator = st.sys;
    assign led_latched    = st.led;
    assign relay_out      = st.rel_out;
    assign scada_latched  = st.scd;
    assign trip_latched   = st.trip;
    assign led_test_red   = st.test == LAC_T_RED;
    assign led_test_green = st.test == LAC_T_GREEN;
    assign menu_open      = st.menu;
    assign pw_request     = st.pw_wait;

    sequence s_red_end;
        st.test == LAC_T_RED && st.test_cnt == CW'(TEST_CYC - 1) && !req.led;
    endsequence
    a_red_to_green: assert property (@(posedge hclk) disable iff (!hresetn)
        s_red_end |=> st.test == LAC_T_GREEN)
        else $error("red phase did not hand over to green");
    a_led_test_start: assert property (@(posedge hclk) disable iff (!hresetn)
        req.led |=> st.test == LAC_T_RED && st.test_cnt == '0)
        else $error("led clear did not start test");
    a_led_held_src: assert property (@(posedge hclk) disable iff (!hresetn)
        st.s2.led_src[0] |=> st.led[0])
        else $error("led latch cleared while source active");
    a_remote_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.ctrl[LAC_CTRL_PERMIT] |-> remote == '0)
        else $error("remote clear taken without permit");
    a_param_no_key: assert property (@(posedge hclk) disable iff (!hresetn)
        st.s2.param_mode |=> st.key_cnt == '0)
        else $error("key timed in parameter mode");
    a_nothing_scope: assert property (@(posedge hclk) disable iff (!hresetn)
        long_hit && scope == LAC_SC_NOTHING && st.pend == '0 |=> st.pend == '0)
        else $error("long press acted with scope nothing");
    a_nopw_long: assert property (@(posedge hclk) disable iff (!hresetn)
        long_hit && scope == LAC_SC_LED_NOPW |=> st.pend.led && !st.pw_wait)
        else $error("led-only long press wrong");
    a_all_long: assert property (@(posedge hclk) disable iff (!hresetn)
        long_hit && scope == LAC_SC_ALL |=> st.pend.rel && st.pend.scd && st.pend.led)
        else $error("everything scope incomplete");
    a_relay_offdly: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(st.rel[0]) |-> st.rel_out[0] [*8])
        else $error("relay released before off-delay");
endmodule // lac_top
`default_nettype wire

// >>> test/lac_panel.sv
// front panel model: clear key and wrench softkey as the operator works them
`timescale 1ns/1ps
`default_nettype none
module lac_panel (
    input  wire logic       hclk,
    input  wire logic       go,
    input  wire logic [7:0] hold,
    input  wire logic       conf,
    output logic            key,
    output logic            wrench
);
    logic [7:0] key_cnt = 8'h00;
    logic [2:0] wr_cnt  = 3'h0;

    // key held for exactly hold cycles, so the bench picks short or long
    always_ff @(posedge hclk)
    begin
        key_cnt <= go ? hold : ((key_cnt != 8'h00) ? key_cnt - 8'h01 : key_cnt);
        wr_cnt  <= conf ? 3'h4 : ((wr_cnt != 3'h0) ? wr_cnt - 3'h1 : wr_cnt);
    end

    assign key    = (key_cnt != 8'h00);
    // confirm held four cycles so it outlives the two-stage input sync
    assign wrench = (wr_cnt != 3'h0);
endmodule // lac_panel
`default_nettype wire

// >>> test/lac_top_bench.sv
// self-checking bench of the latch acknowledge controller
`timescale 1ns/1ps
`default_nettype none
module lac_top_bench;
    import lac_pkg::*;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    lac_in_type  drv     = '0;
    lac_in_type  pins;
    logic        go      = 1'b0;
    logic [7:0]  hold    = 8'h00;
    logic        conf    = 1'b0;
    logic        pkey;
    logic        pwr;
    logic        sys_ind;
    logic [15:0] led;
    logic [7:0]  rel;
    logic [7:0]  scd;
    logic [3:0]  trip;
    logic        red;
    logic        green;
    logic        menu;
    logic        pwreq;
    int          bad_count   = 0;
    int          check_count = 0;
    int          cycles      = 0;

    always #12.5 hclk = ~hclk;

    always_comb
    begin
        pins        = drv;
        pins.key    = pkey;
        pins.wrench = pwr;
    end

    lac_top #(.LONG_CYC(20), .TEST_CYC(10), .OFFDLY_CYC(10)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
        .system_indicator(sys_ind), .led_latched(led), .relay_out(rel),
        .scada_latched(scd), .trip_latched(trip), .led_test_red(red),
        .led_test_green(green), .menu_open(menu), .pw_request(pwreq));

    lac_panel i_panel (.hclk(hclk), .go(go), .hold(hold), .conf(conf), .key(pkey), .wrench(pwr));

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_rdy();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
        check("resp okay", hresp, 1'b0);
    endtask

    task automatic confirm();
        @(posedge hclk);
        conf <= 1'b1;
        @(posedge hclk);
        conf <= 1'b0;
        cyc(8);
    endtask

    // sources pulse high then drop, so every latch can be cleared afterwards
    task automatic latch_all();
        @(posedge hclk);
        drv.sys_src  <= 1'b1;
        drv.led_src  <= 16'hFFFF;
        drv.rel_src  <= 8'hFF;
        drv.scd_src  <= 8'hFF;
        drv.trip_src <= 4'hF;
        cyc(4);
        drv <= '0;
        cyc(6);
    endtask

    task automatic press(input logic [7:0] n);
        @(posedge hclk);
        go   <= 1'b1;
        hold <= n;
        @(posedge hclk);
        go   <= 1'b0;
        cyc(n + 8);
    endtask

    task automatic t_remote();
        rdchk("ctrl reset", LAC_CTRL_ADDR, 32'h10);
        rdchk("unmapped", 8'h40, 32'h0);
        latch_all();
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_LED);
        cyc(3);
        check("led permit off", led, 16'hFFFF);
        wr(LAC_CTRL_ADDR, 32'h11);
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_LED);
        cyc(3);
        check("led cmd", led, 16'h0);
        check("test red", red, 1'b1);
        check("sys kept", sys_ind, 1'b1);
        cyc(12);
        check("test green", {red, green}, 2'b01);
        cyc(12);
        check("test done", {red, green}, 2'b00);
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_SYS);
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_SCD);
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_SG);
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_REL);
        cyc(3);
        check("sys cmd", sys_ind, 1'b0);
        check("scada cmd", scd, 8'h0);
        check("trip unit", trip, 4'hE);
        check("relay held", rel, 8'hFF);
        cyc(20);
        check("relay off", rel, 8'h0);
    endtask

    task automatic t_alarm();
        latch_all();
        @(posedge hclk);
        drv.led_src <= 16'h0008;
        cyc(4);
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_LED);
        cyc(3);
        check("source wins", led, 16'h0008);
        drv.led_src <= 16'h0;
        latch_all();
        wr(LAC_ALMSEL_ADDR, 32'h5);
        wr(LAC_CTRL_ADDR, 32'h10);
        drv.alarm <= 1'b1;
        cyc(4);
        drv.alarm <= 1'b0;
        cyc(3);
        check("alarm permit off", led, 16'hFFFF);
        wr(LAC_CTRL_ADDR, 32'h11);
        drv.alarm <= 1'b1;
        cyc(4);
        drv.alarm <= 1'b0;
        cyc(3);
        check("alarm leds", led, 16'hFFFA);
        check("alarm relays", rel, 8'hFF);
        wr(LAC_CMD_ADDR, 32'h1 << LAC_CMD_ALL);
        cyc(3);
        check("all cmd", {led, scd, trip}, 28'h0);
        cyc(20);
        check("all relay", rel, 8'h0);
    endtask

    // pw: bit1 level-one password empty, bit0 password entered
    task automatic t_long(input logic [3:0] c, input logic [1:0] pw, input logic pm,
                          input logic [15:0] el, input logic [7:0] er, input logic [7:0] es,
                          input logic ep);
        latch_all();
        wr(LAC_CTRL_ADDR, ({28'h0, c} << 4) | {29'h0, pw, 1'b1});
        drv.param_mode <= pm;
        press(8'd26);
        cyc(20);
        drv.param_mode <= 1'b0;
        check("long led", led, el);
        check("long relay", rel, er);
        check("long scada", {scd, trip}, {es, es[3:0]});
        check("pw wait", pwreq, ep);
    endtask

    task automatic t_menu();
        latch_all();
        wr(LAC_CTRL_ADDR, 32'h02);
        // the param-mode press left the menu open; confirm an empty selection
        confirm();
        check("menu closed", menu, 1'b0);
        press(8'd5);
        check("menu", menu, 1'b1);
        check("short no clear", led, 16'hFFFF);
        wr(LAC_MENU_ADDR, 32'h0C);
        confirm();
        cyc(17);
        check("menu relay", rel, 8'h0);
        check("menu scada", scd, 8'h0);
        check("menu led kept", led, 16'hFFFF);
    endtask

    initial
    begin
        cyc(16);
        hresetn <= 1'b1;
        t_remote();
        t_alarm();
        t_long(4'h0, 2'h0, 1'b0, 16'hFFFF, 8'hFF, 8'hFF, 1'b0);
        t_long(4'h1, 2'h0, 1'b0, 16'h0, 8'hFF, 8'hFF, 1'b0);
        t_long(4'h1, 2'h0, 1'b1, 16'hFFFF, 8'hFF, 8'hFF, 1'b0);
        t_long(4'h2, 2'h0, 1'b0, 16'hFFFF, 8'hFF, 8'hFF, 1'b1);
        t_long(4'h2, 2'h1, 1'b0, 16'h0, 8'hFF, 8'hFF, 1'b0);
        t_long(4'h3, 2'h0, 1'b0, 16'hFFFF, 8'hFF, 8'hFF, 1'b1);
        t_long(4'h3, 2'h2, 1'b0, 16'h0, 8'h0, 8'hFF, 1'b0);
        t_long(4'h4, 2'h2, 1'b0, 16'h0, 8'h0, 8'h0, 1'b0);
        t_menu();
        final_report();
    end
endmodule // lac_top_bench
`default_nettype wire
